// >>> src/ifec_pkg.sv
// Package: register map, field positions, edge codes and bus carrier of the interrupt block
`default_nettype none

package ifec_pkg;

   // ----------------------------------------------------------------
   // Widths and sizes
   // ----------------------------------------------------------------
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned NUM_PINS = 2;
   localparam int unsigned NUM_GROUPS = 3;
   localparam int unsigned GROUP_SRC = 4;
   localparam int unsigned NUM_REQ = 7;
   localparam int unsigned EVT_W = 5;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_EDGE_SEL = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_CTRL0 = 4'h1;
   localparam logic [ADDR_W-1:0] OFF_CTRL1 = 4'h2;
   localparam logic [ADDR_W-1:0] OFF_GROUP0 = 4'h3;
   localparam logic [ADDR_W-1:0] OFF_EVT_STATUS = 4'h6;
   localparam logic [ADDR_W-1:0] OFF_EVT_MASK = 4'h7;

   // ----------------------------------------------------------------
   // Reset values and writable bit masks
   // ----------------------------------------------------------------
   localparam logic [DATA_W-1:0] RST_REG = 8'h00;
   localparam logic [EVT_W-1:0] RST_EVT = 5'h00;
   localparam logic [DATA_W-1:0] EDGE_USED_MASK = 8'h0f;
   localparam logic [DATA_W-1:0] CTRL0_USED_MASK = 8'h7f;
   localparam logic [NUM_GROUPS-1:0][DATA_W-1:0] GROUP_USED_MASK = {8'h33, 8'hff, 8'hff};

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int unsigned EDGE_A_LSB = 0;
   localparam int unsigned EDGE_B_LSB = 2;
   localparam int unsigned GLOBAL_EN_BIT = 0;
   localparam int unsigned PIN_A_EN_BIT = 1;
   localparam int unsigned PIN_B_EN_BIT = 2;
   localparam int unsigned CONV_EN_BIT = 3;
   localparam int unsigned PIN_A_FLAG_BIT = 4;
   localparam int unsigned PIN_B_FLAG_BIT = 5;
   localparam int unsigned CONV_FLAG_BIT = 6;
   localparam int unsigned GRP_EN_LSB = 0;
   localparam int unsigned OVP_EN_BIT = 3;
   localparam int unsigned GRP_FLAG_LSB = 4;
   localparam int unsigned OVP_FLAG_BIT = 7;
   localparam int unsigned SRC_FLAG_LSB = 4;
   localparam int unsigned EVT_CORE_BIT = 4;

   // Edge selection codes
   typedef enum logic [1:0] {
      EDGE_OFF = 2'h0,
      EDGE_RISE = 2'h1,
      EDGE_FALL = 2'h2,
      EDGE_BOTH = 2'h3
   } ifec_edge_type;

   // Register port request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } ifec_bus_req_type;

endpackage

`default_nettype wire

// >>> src/ifec_intc.sv
// Interrupt flag and enable control: edge detection, request flags, gating toward the core
`timescale 1ns/10ps
`default_nettype none

module ifec_intc (
   // Clock and reset
   input wire logic clock_i,
   input wire logic reset_i,
   // Register port
   input wire ifec_pkg::ifec_bus_req_type bus_i,
   output logic [ifec_pkg::DATA_W-1:0] rdata_o,
   // External interrupt pins
   input wire logic ext_irq_pin_a_i,
   input wire logic ext_irq_pin_b_i,
   // Peripheral request pulses
   input wire logic converter_req_i,
   input wire logic overvoltage_req_i,
   input wire logic [ifec_pkg::NUM_GROUPS-1:0][ifec_pkg::GROUP_SRC-1:0] group_src_req_i,
   // Core request and block interrupt
   output logic core_irq_o,
   output logic irq_o
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [ifec_pkg::DATA_W-1:0] edge_sel;
   logic [ifec_pkg::DATA_W-1:0] ctrl0;
   logic [ifec_pkg::DATA_W-1:0] ctrl1;
   logic [ifec_pkg::DATA_W-1:0] group_reg [ifec_pkg::NUM_GROUPS];
   logic [ifec_pkg::EVT_W-1:0] evt_status;
   logic [ifec_pkg::EVT_W-1:0] evt_mask;
   logic [ifec_pkg::NUM_PINS-1:0] pin_now;
   logic [ifec_pkg::NUM_PINS-1:0] pin_prev;
   logic [ifec_pkg::NUM_PINS-1:0] pin_hit;
   logic [ifec_pkg::NUM_GROUPS-1:0] group_pending;
   logic [ifec_pkg::NUM_REQ-1:0] req_vec;
   logic next_core_irq;
   logic [ifec_pkg::EVT_W-1:0] evt_set;
   logic [ifec_pkg::EVT_W-1:0] next_evt_status;
   logic [ifec_pkg::DATA_W-1:0] next_rdata;
   logic wr_edge;
   logic wr_ctrl0;
   logic wr_ctrl1;
   logic wr_status;
   logic wr_mask;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   assign wr_edge = bus_i.wr && (bus_i.addr == ifec_pkg::OFF_EDGE_SEL);
   assign wr_ctrl0 = bus_i.wr && (bus_i.addr == ifec_pkg::OFF_CTRL0);
   assign wr_ctrl1 = bus_i.wr && (bus_i.addr == ifec_pkg::OFF_CTRL1);
   assign wr_status = bus_i.wr && (bus_i.addr == ifec_pkg::OFF_EVT_STATUS);
   assign wr_mask = bus_i.wr && (bus_i.addr == ifec_pkg::OFF_EVT_MASK);

   // ----------------------------------------------------------------
   // External pin edge detection
   // ----------------------------------------------------------------
   assign pin_now = {ext_irq_pin_b_i, ext_irq_pin_a_i};

   // Previous pin level; pins are already synchronous to the clock
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         pin_prev <= '0;
      end else begin
         pin_prev <= pin_now;
      end
   end

   // Edge selection register, upper nibble never stored
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         edge_sel <= ifec_pkg::RST_REG;
      end else if (wr_edge) begin
         edge_sel <= bus_i.wdata & ifec_pkg::EDGE_USED_MASK;
      end
   end

   // Per-pin edge decode; pin 0 is pin a, pin 1 is pin b
   for (genvar p = 0; p < ifec_pkg::NUM_PINS; p++) begin : g_pin
      ifec_pkg::ifec_edge_type sel;
      logic rise;
      logic fall;
      assign sel = ifec_pkg::ifec_edge_type'(edge_sel[2*p +: 2]);
      assign rise = pin_now[p] && !pin_prev[p];
      assign fall = !pin_now[p] && pin_prev[p];
      assign pin_hit[p] = ((sel == ifec_pkg::EDGE_RISE) && rise)
                       || ((sel == ifec_pkg::EDGE_FALL) && fall)
                       || ((sel == ifec_pkg::EDGE_BOTH) && (rise || fall));
   end

   // ----------------------------------------------------------------
   // Primary control register 0
   // ----------------------------------------------------------------
   // Hardware sets come after the software write so a set in the clearing cycle wins
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         ctrl0 <= ifec_pkg::RST_REG;
      end else begin
         if (wr_ctrl0) begin
            ctrl0 <= bus_i.wdata & ifec_pkg::CTRL0_USED_MASK;
         end
         if (pin_hit[0]) begin
            ctrl0[ifec_pkg::PIN_A_FLAG_BIT] <= 1'b1;
         end
         if (pin_hit[1]) begin
            ctrl0[ifec_pkg::PIN_B_FLAG_BIT] <= 1'b1;
         end
         if (converter_req_i) begin
            ctrl0[ifec_pkg::CONV_FLAG_BIT] <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Multi-function group registers
   // ----------------------------------------------------------------
   // Upper nibble holds source flags, lower nibble the matching enables
   for (genvar g = 0; g < ifec_pkg::NUM_GROUPS; g++) begin : g_group
      logic [ifec_pkg::GROUP_SRC-1:0] src_set;
      // Group 2 has only two sources; its spare request lines are masked off
      assign src_set = group_src_req_i[g]
                    & ifec_pkg::GROUP_USED_MASK[g][ifec_pkg::SRC_FLAG_LSB +: 4];

      always_ff @(posedge clock_i or posedge reset_i) begin
         if (reset_i) begin
            group_reg[g] <= ifec_pkg::RST_REG;
         end else begin
            if (bus_i.wr && (bus_i.addr == ifec_pkg::OFF_GROUP0 + 4'(g))) begin
               group_reg[g] <= bus_i.wdata & ifec_pkg::GROUP_USED_MASK[g];
            end
            for (int s = 0; s < ifec_pkg::GROUP_SRC; s++) begin
               if (src_set[s]) begin
                  group_reg[g][ifec_pkg::SRC_FLAG_LSB + s] <= 1'b1;
               end
            end
         end
      end

      assign group_pending[g] = |(group_reg[g][ifec_pkg::SRC_FLAG_LSB +: 4]
                                 & group_reg[g][3:0]);
   end

   // ----------------------------------------------------------------
   // Primary control register 1
   // ----------------------------------------------------------------
   // A group flag re-arms while any enabled source in it still waits
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         ctrl1 <= ifec_pkg::RST_REG;
      end else begin
         if (wr_ctrl1) begin
            ctrl1 <= bus_i.wdata;
         end
         if (overvoltage_req_i) begin
            ctrl1[ifec_pkg::OVP_FLAG_BIT] <= 1'b1;
         end
         for (int g = 0; g < ifec_pkg::NUM_GROUPS; g++) begin
            if (group_pending[g]) begin
               ctrl1[ifec_pkg::GRP_FLAG_LSB + g] <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Request gating toward the core
   // ----------------------------------------------------------------
   // flag and own enable
   assign req_vec[0] = ctrl0[ifec_pkg::PIN_A_FLAG_BIT] && ctrl0[ifec_pkg::PIN_A_EN_BIT];
   assign req_vec[1] = ctrl0[ifec_pkg::PIN_B_FLAG_BIT] && ctrl0[ifec_pkg::PIN_B_EN_BIT];
   assign req_vec[2] = ctrl0[ifec_pkg::CONV_FLAG_BIT] && ctrl0[ifec_pkg::CONV_EN_BIT];
   assign req_vec[3] = ctrl1[ifec_pkg::OVP_FLAG_BIT] && ctrl1[ifec_pkg::OVP_EN_BIT];
   assign req_vec[6:4] = ctrl1[ifec_pkg::GRP_FLAG_LSB +: 3] & ctrl1[ifec_pkg::GRP_EN_LSB +: 3];

   assign next_core_irq = ctrl0[ifec_pkg::GLOBAL_EN_BIT] && (|req_vec);

   // core suspend request, held while the global enable is set and any gated request stands
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         core_irq_o <= 1'b0;
      end else begin
         core_irq_o <= next_core_irq;
      end
   end

   // ----------------------------------------------------------------
   // Event status, mask and block interrupt
   // ----------------------------------------------------------------
   // Events: pin a, pin b, converter, over-voltage, new core request
   assign evt_set = {next_core_irq && !core_irq_o, overvoltage_req_i, converter_req_i,
                     pin_hit[1], pin_hit[0]};

   // Write one to clear; a new event in the same cycle keeps its bit set
   assign next_evt_status = (evt_status
                            & ~(wr_status ? bus_i.wdata[ifec_pkg::EVT_W-1:0] : '0))
                          | evt_set;

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         evt_status <= ifec_pkg::RST_EVT;
      end else begin
         evt_status <= next_evt_status;
      end
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         evt_mask <= ifec_pkg::RST_EVT;
      end else if (wr_mask) begin
         evt_mask <= bus_i.wdata[ifec_pkg::EVT_W-1:0];
      end
   end

   // Built from the next status so the output tracks the stored bits
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         irq_o <= 1'b0;
      end else if (wr_mask) begin
         irq_o <= |(next_evt_status & bus_i.wdata[ifec_pkg::EVT_W-1:0]);
      end else begin
         irq_o <= |(next_evt_status & evt_mask);
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // Unmapped offsets read zero; data stands only in the cycle after the strobe
   always_comb begin
      next_rdata = '0;
      case (bus_i.addr)
         ifec_pkg::OFF_EDGE_SEL: next_rdata = edge_sel;
         ifec_pkg::OFF_CTRL0: next_rdata = ctrl0;
         ifec_pkg::OFF_CTRL1: next_rdata = ctrl1;
         4'h3: next_rdata = group_reg[0];
         4'h4: next_rdata = group_reg[1];
         4'h5: next_rdata = group_reg[2];
         ifec_pkg::OFF_EVT_STATUS: next_rdata = {3'h0, evt_status};
         ifec_pkg::OFF_EVT_MASK: next_rdata = {3'h0, evt_mask};
         default: next_rdata = '0;
      endcase
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         rdata_o <= ifec_pkg::RST_REG;
      end else if (bus_i.rd) begin
         rdata_o <= next_rdata;
      end else begin
         rdata_o <= '0;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_edge_b_rise: assert property (
      @(posedge clock_i) disable iff (reset_i)
      (edge_sel[3:2] == 2'h1 && pin_now[1] && !pin_prev[1])
         |=> ctrl0[ifec_pkg::PIN_B_FLAG_BIT])
      else $error("pin b rising edge did not set its flag");

   a_edge_b_nofall: assert property (
      @(posedge clock_i) disable iff (reset_i)
      (edge_sel[3:2] == 2'h1 && !pin_now[1] && pin_prev[1]
       && !ctrl0[ifec_pkg::PIN_B_FLAG_BIT] && !wr_ctrl0)
         |=> !ctrl0[ifec_pkg::PIN_B_FLAG_BIT])
      else $error("pin b falling edge set flag in rising mode");

   a_edge_a_off: assert property (
      @(posedge clock_i) disable iff (reset_i)
      (edge_sel[1:0] == 2'h0 && !ctrl0[ifec_pkg::PIN_A_FLAG_BIT] && !wr_ctrl0)
         |=> !ctrl0[ifec_pkg::PIN_A_FLAG_BIT])
      else $error("pin a flag set while detection disabled");

   a_edge_a_fall: assert property (
      @(posedge clock_i) disable iff (reset_i)
      (edge_sel[1:0] == 2'h2 && !pin_now[0] && pin_prev[0])
         |=> ctrl0[ifec_pkg::PIN_A_FLAG_BIT])
      else $error("pin a falling edge did not set its flag");

   a_global_block: assert property (
      @(posedge clock_i) disable iff (reset_i)
      !ctrl0[ifec_pkg::GLOBAL_EN_BIT] |=> !core_irq_o)
      else $error("core request raised with global enable off");

   a_conv_flag: assert property (
      @(posedge clock_i) disable iff (reset_i)
      converter_req_i |=> ctrl0[ifec_pkg::CONV_FLAG_BIT])
      else $error("converter request lost");

   a_ovp_flag: assert property (
      @(posedge clock_i) disable iff (reset_i)
      overvoltage_req_i |=> ctrl1[ifec_pkg::OVP_FLAG_BIT])
      else $error("over-voltage request lost");

   a_group_summary: assert property (
      @(posedge clock_i) disable iff (reset_i)
      (group_reg[1][5] && group_reg[1][1]) |=> ctrl1[ifec_pkg::GRP_FLAG_LSB + 1])
      else $error("group 1 flag does not follow its sources");

   a_group_enable: assert property (
      @(posedge clock_i) disable iff (reset_i)
      (ctrl0[ifec_pkg::GLOBAL_EN_BIT] && ctrl1[4] && ctrl1[0]) |=> core_irq_o)
      else $error("enabled group 0 did not reach the core");

   a_reserved_zero: assert property (
      @(posedge clock_i) disable iff (reset_i)
      (bus_i.rd && (bus_i.addr == ifec_pkg::OFF_CTRL0 || bus_i.addr == ifec_pkg::OFF_EDGE_SEL))
         |=> (rdata_o[7] == 1'b0) && (edge_sel[7:4] == 4'h0))
      else $error("reserved bits read non-zero");

   a_core_suspend: assert property (
      @(posedge clock_i) disable iff (reset_i)
      (ctrl0[ifec_pkg::GLOBAL_EN_BIT] && ctrl0[ifec_pkg::CONV_EN_BIT] && converter_req_i
       && !wr_ctrl0)
         |-> ##2 core_irq_o)
      else $error("enabled converter request did not suspend the core");

   a_timer_src: assert property (
      @(posedge clock_i) disable iff (reset_i)
      group_src_req_i[0][3] |=> group_reg[0][7])
      else $error("timer comparator A flag not set");

   a_req_gate: assert property (
      @(posedge clock_i) disable iff (reset_i)
      core_irq_o |-> $past(ctrl0[ifec_pkg::GLOBAL_EN_BIT]) && ($past(req_vec) != 7'h00))
      else $error("core request without flag, enable and global enable");

endmodule // ifec_intc

`default_nettype wire

// >>> sim/ifec_far_model.sv
// Far-side model: peripheral request sources and external pin drivers feeding the interrupt block
`timescale 1ns/10ps
`default_nettype none

module ifec_far_model (
   // Clock
   input wire logic clock_i,
   // External pins
   output logic pin_a_o,
   output logic pin_b_o,
   // Peripheral request pulses
   output logic conv_o,
   output logic ovp_o,
   output logic [ifec_pkg::NUM_GROUPS-1:0][ifec_pkg::GROUP_SRC-1:0] grp_o
);
   // Quiet lines at time zero so the block sees no spurious edge after reset
   initial begin
      pin_a_o = 1'b0;
      pin_b_o = 1'b0;
      conv_o = 1'b0;
      ovp_o = 1'b0;
      grp_o = '0;
   end

   // Pins move only after a clock edge; the block samples them synchronously
   task automatic set_pin(input int p, input logic v);
      @(posedge clock_i);
      if (p == 0) begin
         pin_a_o <= v;
      end else begin
         pin_b_o <= v;
      end
   endtask

   // peripheral request sources: one-cycle pulse on converter, over-voltage or a group source
   task automatic pulse(input int kind, input int g, input int s);
      @(posedge clock_i);
      case (kind)
         0: conv_o <= 1'b1;
         1: ovp_o <= 1'b1;
         default: grp_o[g][s] <= 1'b1;
      endcase
      @(posedge clock_i);
      conv_o <= 1'b0;
      ovp_o <= 1'b0;
      grp_o <= '0;
   endtask
endmodule // ifec_far_model

`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking testbench of the interrupt flag and enable block
`timescale 1ns/10ps
`default_nettype none

module tb_top;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic clock_i = 1'b0;
   logic reset_i = 1'b1;
   ifec_pkg::ifec_bus_req_type bus = '0;
   logic [7:0] rdata_o;
   logic pin_a, pin_b, conv, overvoltage_protection, core_irq_o, irq_o;
   logic [ifec_pkg::NUM_GROUPS-1:0][ifec_pkg::GROUP_SRC-1:0] grp;
   int fails = 0;
   int n_checks = 0;

   // 10 MHz system clock
   always #50 clock_i = ~clock_i;

   ifec_intc u_ifec_intc (
      .clock_i(clock_i), .reset_i(reset_i), .bus_i(bus), .rdata_o(rdata_o),
      .ext_irq_pin_a_i(pin_a), .ext_irq_pin_b_i(pin_b), .converter_req_i(conv),
      .overvoltage_req_i(overvoltage_protection), .group_src_req_i(grp), .core_irq_o(core_irq_o),
      .irq_o(irq_o));

   ifec_far_model u_ifec_far_model (
      .clock_i(clock_i), .pin_a_o(pin_a), .pin_b_o(pin_b), .conv_o(conv),
      .ovp_o(overvoltage_protection), .grp_o(grp));

   // ----------------------------------------------------------------
   // Compare, bus and expectation helpers
   // ----------------------------------------------------------------
   task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: register read %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic check_line(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: request line %b, expected %b", $time, got, exp);
      end
   endtask

   // One-cycle write strobe, released at the next edge
   task automatic wr(input logic [ifec_pkg::ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge clock_i);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock_i);
      bus <= '0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample just past that edge
   task automatic rd_chk(input logic [ifec_pkg::ADDR_W-1:0] a, input logic [7:0] e);
      @(posedge clock_i);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clock_i);
      bus <= '0;
      #1 check_reg(rdata_o, e);
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask

   function automatic logic [7:0] pin_flag(input int p, input logic hit);
      return hit ? (8'h10 << p) : 8'h00;
   endfunction

   function automatic logic [7:0] grp_reg(input int s);
      return (8'h10 << s) | (8'h01 << s);
   endfunction

   task automatic tally_and_finish;
      $display("checks %0d, fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Watchdog: the whole sequence needs well under 5000 cycles
   initial begin
      #(2_000_000);
      fails++;
      tally_and_finish();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      int g, s;
      void'($urandom(32'h1a43a377));
      repeat (3) @(posedge clock_i);
      reset_i <= 1'b0;
      // Every offset, mapped or not, reads zero after reset
      for (int a = 0; a < 16; a++) rd_chk(a[3:0], 8'h00);
      // Reserved bits read zero and ignore writes; unmapped writes vanish
      wr(ifec_pkg::OFF_EDGE_SEL, 8'hff);
      rd_chk(ifec_pkg::OFF_EDGE_SEL, 8'h0f);
      wr(ifec_pkg::OFF_CTRL0, 8'hff);
      rd_chk(ifec_pkg::OFF_CTRL0, 8'h7f);
      wr(ifec_pkg::OFF_CTRL0, 8'h00);
      wr(4'h9, 8'hff);
      rd_chk(4'h9, 8'h00);
      wr(ifec_pkg::OFF_GROUP0 + 4'h2, 8'hff);
      rd_chk(ifec_pkg::OFF_GROUP0 + 4'h2, 8'h33);
      wr(ifec_pkg::OFF_GROUP0 + 4'h2, 8'h00);
      // Every edge mode on both pins: rising then falling transition
      for (int p = 0; p < 2; p++) begin
         for (int m = 0; m < 4; m++) begin
            wr(ifec_pkg::OFF_EDGE_SEL, 8'(m << (2 * p)));
            wr(ifec_pkg::OFF_CTRL0, 8'h00);
            u_ifec_far_model.set_pin(p, 1'b1);
            wait_cyc(3);
            rd_chk(ifec_pkg::OFF_CTRL0, pin_flag(p, m[0]));
            wr(ifec_pkg::OFF_CTRL0, 8'h00);
            u_ifec_far_model.set_pin(p, 1'b0);
            wait_cyc(3);
            rd_chk(ifec_pkg::OFF_CTRL0, pin_flag(p, m[1]));
         end
      end
      wr(ifec_pkg::OFF_EDGE_SEL, 8'h00);
      wr(ifec_pkg::OFF_CTRL0, 8'h00);
      // Converter: flag set with global off must not reach the core
      wr(ifec_pkg::OFF_CTRL0, 8'h08);
      u_ifec_far_model.pulse(0, 0, 0);
      wait_cyc(3);
      check_line(core_irq_o, 1'b0);
      rd_chk(ifec_pkg::OFF_CTRL0, 8'h48);
      wr(ifec_pkg::OFF_CTRL0, 8'h49);
      wait_cyc(2);
      check_line(core_irq_o, 1'b1);
      // Fresh enabled converter request reaches the core two cycles on
      wr(ifec_pkg::OFF_CTRL0, 8'h09);
      u_ifec_far_model.pulse(0, 0, 0);
      wait_cyc(1);
      check_line(core_irq_o, 1'b1);
      wr(ifec_pkg::OFF_CTRL0, 8'h41);
      wait_cyc(2);
      check_line(core_irq_o, 1'b0);
      // Over-voltage source with its own enable
      wr(ifec_pkg::OFF_CTRL1, 8'h08);
      u_ifec_far_model.pulse(1, 0, 0);
      wait_cyc(3);
      rd_chk(ifec_pkg::OFF_CTRL1, 8'h88);
      // Read data stand one cycle only, then fall back to zero
      wait_cyc(1);
      check_reg(rdata_o, 8'h00);
      check_line(core_irq_o, 1'b1);
      wr(ifec_pkg::OFF_CTRL1, 8'h00);
      wr(ifec_pkg::OFF_CTRL0, 8'h01);
      // Random group sources: source flag, group summary flag, core request
      for (int i = 0; i < 10; i++) begin
         // First two rounds are fixed corners: timer compare A, then group 1 source 1
         g = (i < 2) ? i : $urandom % 3;
         s = (i < 2) ? 3 - 2 * i : $urandom % ((g == 2) ? 2 : 4);
         wr(ifec_pkg::OFF_GROUP0 + 4'(g), 8'h01 << s);
         wr(ifec_pkg::OFF_CTRL1, 8'h01 << g);
         u_ifec_far_model.pulse(2, g, s);
         wait_cyc(4);
         rd_chk(ifec_pkg::OFF_GROUP0 + 4'(g), grp_reg(s));
         rd_chk(ifec_pkg::OFF_CTRL1, grp_reg(g));
         check_line(core_irq_o, 1'b1);
         wr(ifec_pkg::OFF_GROUP0 + 4'(g), 8'h00);
         wr(ifec_pkg::OFF_CTRL1, 8'h00);
      end
      // Unused group 2 source is ignored
      u_ifec_far_model.pulse(2, 2, 3);
      wait_cyc(3);
      rd_chk(ifec_pkg::OFF_GROUP0 + 4'h2, 8'h00);
      // Masked group with a pending flag does not reach the core
      wr(ifec_pkg::OFF_GROUP0, 8'h01);
      u_ifec_far_model.pulse(2, 0, 0);
      wait_cyc(4);
      rd_chk(ifec_pkg::OFF_CTRL1, 8'h10);
      check_line(core_irq_o, 1'b0);
      wr(ifec_pkg::OFF_GROUP0, 8'h00);
      wr(ifec_pkg::OFF_CTRL0, 8'h00);
      // Block interrupt: masked event, sticky status, write-one clear
      wr(ifec_pkg::OFF_EVT_STATUS, 8'hff);
      wr(ifec_pkg::OFF_EVT_MASK, 8'hff);
      rd_chk(ifec_pkg::OFF_EVT_MASK, 8'h1f);
      wr(ifec_pkg::OFF_EVT_MASK, 8'h04);
      u_ifec_far_model.pulse(0, 0, 0);
      wait_cyc(2);
      check_line(irq_o, 1'b1);
      rd_chk(ifec_pkg::OFF_EVT_STATUS, 8'h04);
      wr(ifec_pkg::OFF_EVT_MASK, 8'h00);
      wait_cyc(1);
      check_line(irq_o, 1'b0);
      wr(ifec_pkg::OFF_EVT_MASK, 8'h04);
      wr(ifec_pkg::OFF_EVT_STATUS, 8'h04);
      wait_cyc(2);
      check_line(irq_o, 1'b0);
      rd_chk(ifec_pkg::OFF_EVT_STATUS, 8'h00);
      // Mid-run reset wipes the converter and group flags left set above
      @(posedge clock_i);
      reset_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      reset_i <= 1'b0;
      rd_chk(ifec_pkg::OFF_CTRL0, 8'h00);
      rd_chk(ifec_pkg::OFF_CTRL1, 8'h00);
      check_line(core_irq_o, 1'b0);
      tally_and_finish();
   end
endmodule // tb_top

`default_nettype wire
